// ==== rtl/sbt_regs.svh ====
// Constants of the boundary-scan test port: codes, widths, reset values, timing
`ifndef SBT_REGS_SVH
`define SBT_REGS_SVH
`define SBT_IR_W 3
`define SBT_ID_W 32
`define SBT_IR_CAPTURE 3'h1
`define SBT_OP_EXTEST 3'h0
`define SBT_OP_IDCODE 3'h1
`define SBT_OP_SAMPLEZ 3'h2
`define SBT_OP_RSVD3 3'h3
`define SBT_OP_SAMPLE 3'h4
`define SBT_OP_RSVD5 3'h5
`define SBT_BYPASS_RST 1'h0
`define SBT_RESET_TMS_EDGES 5
`define SBT_TCK_MIN_NS 50
`define SBT_CLK_NS 10
`define SBT_TCK_MIN_CYC ((`SBT_TCK_MIN_NS + `SBT_CLK_NS - 1) / `SBT_CLK_NS)
`endif

// ==== rtl/sbt_pkg.sv ====
// Types of the boundary-scan test port
`default_nettype none
package sbt_pkg;
  // Controller states, Gray-coded along the shift path
  typedef enum logic [3:0] {
    SBT_RESET = 4'h0, SBT_IDLE = 4'h1, SBT_SEL_DR = 4'h3, SBT_CAP_DR = 4'h2,
    SBT_SH_DR = 4'h6, SBT_EX1_DR = 4'h7, SBT_PA_DR = 4'h5, SBT_EX2_DR = 4'h4,
    SBT_UPD_DR = 4'hc, SBT_SEL_IR = 4'hd, SBT_CAP_IR = 4'hf, SBT_SH_IR = 4'he,
    SBT_EX1_IR = 4'ha, SBT_PA_IR = 4'hb, SBT_EX2_IR = 4'h9, SBT_UPD_IR = 4'h8
  } sbt_state_e;
  // Serial link pins as seen by the device
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_link_in_s;
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbt_link_out_s;
endpackage
`default_nettype wire

// ==== rtl/sbt_tap.sv ====
// Serial boundary-scan test port of the memory, oversampling the test clock
`include "sbt_regs.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Capture-DR loads boundary chain from all input pins; Shift-DR shifts it.
// - TDI enters each register's MSB; TDO leaves from its LSB.
// - ID instruction captures the hardwired 32-bit code and shifts it out.
// - Three-bit instruction register; all eight codes decoded.
// - Never drive the memory core nor preload I/O; only capture.
// - New instruction takes effect only at Update-IR.
// - Code 000 acts like sample and floats memory outputs.
// - Instruction becomes ID at power-up and in test-logic-reset.
// - Sample-with-float shifts boundary chain and floats memory outputs.
// - Sample snapshots pins at Capture-DR without disturbing memory.
// - Update-DR under sample acts like Pause-DR; nothing reaches outputs.
// - Bypass puts the one-bit bypass register in the serial path.
// - Codes: 000 extest, 001 ID, 010 sample-float, 100 sample, 011/101 reserved.
// - Capture-IR loads 01 into the two low instruction bits.
// - Five TMS-high rising edges reset the port; also at power-up.
// - Sample TMS and TDI on rising edge; update TDO on falling edge.
module sbt_tap
  import sbt_pkg::*;
#(
  parameter int unsigned BSR_W = 71,
  parameter logic [`SBT_ID_W-1:0] ID_CODE = 32'h0aa5_5001 // Arbitrary neutral value
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire sbt_link_in_s link_in,
  output sbt_link_out_s link_out,
  input wire logic [BSR_W-1:0] pin_values,
  output logic mem_out_float
);

  typedef struct packed {
    logic [2:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    sbt_state_e state;
    logic [`SBT_IR_W-1:0] ir_shift;
    logic [`SBT_IR_W-1:0] ir;
    logic [BSR_W-1:0] bsr;
    logic [`SBT_ID_W-1:0] idr;
    logic bypass;
    logic tdo;
    logic tdo_oe;
    logic [2:0] tms_high_cnt;
    logic [BSR_W-1:0] pin_meta;
    logic [BSR_W-1:0] pin_sync;
  } sbt_tap_s;

  sbt_tap_s st;
  sbt_tap_s next_st;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  logic [1:0] sel;
  logic ser_bit;

  // Synchronised pins: stage 0 feeds only stage 1
  assign tms_s = st.tms_sync[1];
  assign tdi_s = st.tdi_sync[1];
  assign tck_rise = st.tck_sync[1] & ~st.tck_sync[2];
  assign tck_fall = ~st.tck_sync[1] & st.tck_sync[2];

  // Data register choice: 0 boundary, 1 ID, 2 bypass
  always_comb begin
    case (st.ir)
      `SBT_OP_EXTEST, `SBT_OP_SAMPLEZ, `SBT_OP_SAMPLE: sel = 2'h0;
      `SBT_OP_IDCODE: sel = 2'h1;
      default: sel = 2'h2;
    endcase
  end

  // Bit presented toward TDO, always the LSB of the chosen register
  always_comb begin
    ser_bit = st.bypass;
    if (st.state == SBT_SH_IR) begin
      ser_bit = st.ir_shift[0];
    end else if (sel == 2'h0) begin
      ser_bit = st.bsr[0];
    end else if (sel == 2'h1) begin
      ser_bit = st.idr[0];
    end
  end

  // Floating the memory outputs is the only effect on the memory side
  assign mem_out_float = (st.ir == `SBT_OP_EXTEST) || (st.ir == `SBT_OP_SAMPLEZ);
  assign link_out.tdo = st.tdo;
  assign link_out.tdo_oe = st.tdo_oe;

  // Next-state logic; all link work happens on detected test clock edges
  always_comb begin
    next_st = st;
    next_st.tck_sync = {st.tck_sync[1:0], link_in.tck};
    next_st.tms_sync = {st.tms_sync[0], link_in.tms};
    next_st.tdi_sync = {st.tdi_sync[0], link_in.tdi};
    // Memory balls belong to the fast memory clock, so they are synchronised too
    next_st.pin_meta = pin_values;
    next_st.pin_sync = st.pin_meta;
    if (tck_rise) begin
      // Rising edge samples TMS and TDI
      next_st.tms_high_cnt = tms_s ? ((st.tms_high_cnt == 3'h7) ? 3'h7 : st.tms_high_cnt + 3'h1) : 3'h0;
      case (st.state)
        SBT_RESET: next_st.state = tms_s ? SBT_RESET : SBT_IDLE;
        SBT_IDLE: next_st.state = tms_s ? SBT_SEL_DR : SBT_IDLE;
        SBT_SEL_DR: next_st.state = tms_s ? SBT_SEL_IR : SBT_CAP_DR;
        SBT_CAP_DR: next_st.state = tms_s ? SBT_EX1_DR : SBT_SH_DR;
        SBT_SH_DR: next_st.state = tms_s ? SBT_EX1_DR : SBT_SH_DR;
        SBT_EX1_DR: next_st.state = tms_s ? SBT_UPD_DR : SBT_PA_DR;
        SBT_PA_DR: next_st.state = tms_s ? SBT_EX2_DR : SBT_PA_DR;
        SBT_EX2_DR: next_st.state = tms_s ? SBT_UPD_DR : SBT_SH_DR;
        SBT_UPD_DR: next_st.state = tms_s ? SBT_SEL_DR : SBT_IDLE;
        SBT_SEL_IR: next_st.state = tms_s ? SBT_RESET : SBT_CAP_IR;
        SBT_CAP_IR: next_st.state = tms_s ? SBT_EX1_IR : SBT_SH_IR;
        SBT_SH_IR: next_st.state = tms_s ? SBT_EX1_IR : SBT_SH_IR;
        SBT_EX1_IR: next_st.state = tms_s ? SBT_UPD_IR : SBT_PA_IR;
        SBT_PA_IR: next_st.state = tms_s ? SBT_EX2_IR : SBT_PA_IR;
        SBT_EX2_IR: next_st.state = tms_s ? SBT_UPD_IR : SBT_SH_IR;
        SBT_UPD_IR: next_st.state = tms_s ? SBT_SEL_DR : SBT_IDLE;
        default: next_st.state = SBT_RESET;
      endcase
      // Five TMS-high edges always land in reset, the walk guarantees it
      if (tms_s && st.tms_high_cnt >= 3'(`SBT_RESET_TMS_EDGES - 1)) begin
        next_st.state = SBT_RESET;
      end
      // Register actions of the state being left
      case (st.state)
        SBT_RESET: next_st.ir = `SBT_OP_IDCODE;
        SBT_CAP_DR: begin
          // Capture only; nothing is ever written back to pins or core
          if (sel == 2'h0) next_st.bsr = st.pin_sync;
          if (sel == 2'h1) next_st.idr = ID_CODE;
          if (sel == 2'h2) next_st.bypass = `SBT_BYPASS_RST;
        end
        SBT_SH_DR: begin
          if (sel == 2'h0) next_st.bsr = {tdi_s, st.bsr[BSR_W-1:1]};
          if (sel == 2'h1) next_st.idr = {tdi_s, st.idr[`SBT_ID_W-1:1]};
          if (sel == 2'h2) next_st.bypass = tdi_s;
        end
        SBT_CAP_IR: next_st.ir_shift = {st.ir_shift[2], 2'(`SBT_IR_CAPTURE)};
        SBT_SH_IR: next_st.ir_shift = {tdi_s, st.ir_shift[2:1]};
        // Update-DR holds registers like Pause-DR: no preload stage exists
        SBT_UPD_DR: next_st.bsr = st.bsr;
        default: begin
        end
      endcase
      // Instruction is applied on entry to Update-IR only
      if (next_st.state == SBT_UPD_IR) next_st.ir = st.ir_shift;
      // Entering test-logic-reset restores the ID instruction at once
      if (next_st.state == SBT_RESET) next_st.ir = `SBT_OP_IDCODE;
    end
    if (tck_fall) begin
      // Falling edge drives TDO, enabled only in the two shift states
      next_st.tdo_oe = (st.state == SBT_SH_DR) || (st.state == SBT_SH_IR);
      next_st.tdo = next_st.tdo_oe ? ser_bit : 1'h0;
    end
  end

  // State register; power-up reset leaves ID instruction and TDO floating
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.state <= SBT_RESET;
      st.ir <= `SBT_OP_IDCODE;
      st.ir_shift <= `SBT_OP_IDCODE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Five consecutive high samples of TMS must reach reset; the counter holds the history
  sequence s_tms_fifth;
    tck_rise && tms_s && st.tms_high_cnt >= 3'h4;
  endsequence
  // Shift steps of the boundary, ID and instruction registers, one per detected rising edge
  sequence s_bsr_shift;
    tck_rise && st.state == SBT_SH_DR && sel == 2'h0;
  endsequence
  sequence s_id_shift;
    tck_rise && st.state == SBT_SH_DR && sel == 2'h1;
  endsequence
  sequence s_ir_shift;
    tck_rise && st.state == SBT_SH_IR;
  endsequence
  // Falling edges inside a shift state, where TDO must carry a register's LSB
  sequence s_fall_bsr;
    tck_fall && st.state == SBT_SH_DR && sel == 2'h0;
  endsequence
  sequence s_fall_id;
    tck_fall && st.state == SBT_SH_DR && sel == 2'h1;
  endsequence
  sequence s_fall_byp;
    tck_fall && st.state == SBT_SH_DR && sel == 2'h2;
  endsequence
  sequence s_fall_ir;
    tck_fall && st.state == SBT_SH_IR;
  endsequence
  // Leaving Exit1-IR with TMS high is the direct way into Update-IR from a shift; Exit2-IR is the other
  sequence s_ir_update;
    tck_rise && st.state == SBT_EX1_IR && tms_s;
  endsequence

  AST_BSR_SHIFT: assert property (@(posedge core_clk) disable iff (!resetn)
    s_bsr_shift |=> st.bsr == {$past(tdi_s), $past(st.bsr[BSR_W-1:1])})
    else $error("boundary chain shift wrong");
  AST_ID_SHIFT: assert property (@(posedge core_clk) disable iff (!resetn)
    s_id_shift |=> st.idr == {$past(tdi_s), $past(st.idr[`SBT_ID_W-1:1])})
    else $error("ID register shift wrong");
  AST_IR_SHIFT: assert property (@(posedge core_clk) disable iff (!resetn)
    s_ir_shift |=> st.ir_shift == {$past(tdi_s), $past(st.ir_shift[2:1])})
    else $error("instruction shift wrong");
  AST_TDO_BSR: assert property (@(posedge core_clk) disable iff (!resetn)
    s_fall_bsr |=> link_out.tdo_oe && link_out.tdo == $past(st.bsr[0]))
    else $error("TDO not boundary LSB");
  AST_TDO_ID: assert property (@(posedge core_clk) disable iff (!resetn)
    s_fall_id |=> link_out.tdo_oe && link_out.tdo == $past(st.idr[0]))
    else $error("TDO not ID LSB");
  AST_TDO_BYP: assert property (@(posedge core_clk) disable iff (!resetn)
    s_fall_byp |=> link_out.tdo_oe && link_out.tdo == $past(st.bypass))
    else $error("TDO not bypass bit");
  AST_TDO_IR: assert property (@(posedge core_clk) disable iff (!resetn)
    s_fall_ir |=> link_out.tdo_oe && link_out.tdo == $past(st.ir_shift[0]))
    else $error("TDO not instruction LSB");
  AST_IR_APPLY: assert property (@(posedge core_clk) disable iff (!resetn)
    s_ir_update |=> st.ir == $past(st.ir_shift))
    else $error("instruction not applied at update");

  // Between detected edges nothing of the link may move
  AST_STATE_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !tck_rise |=> $stable(st.state))
    else $error("state moved without a rising edge");
  AST_TDO_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !tck_fall |=> $stable(link_out.tdo) && $stable(link_out.tdo_oe))
    else $error("TDO moved without a falling edge");
  AST_BYP_CAP: assert property (@(posedge core_clk) disable iff (!resetn)
    (tck_rise && st.state == SBT_CAP_DR && sel == 2'h2) |=> !st.bypass)
    else $error("bypass not cleared at capture");
  AST_RESET_IR: assert property (@(posedge core_clk) disable iff (!resetn)
    st.state == SBT_RESET |-> st.ir == `SBT_OP_IDCODE)
    else $error("reset state without ID instruction");
  AST_LEAVE_RESET: assert property (@(posedge core_clk) disable iff (!resetn)
    (tck_rise && st.state == SBT_RESET && !tms_s) |=> st.state == SBT_IDLE)
    else $error("reset did not go to idle");
  AST_BYP_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
    st.ir[2:1] == 2'h3 |-> sel == 2'h2)
    else $error("codes 110 and 111 not bypass");
  AST_ID_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
    st.ir == 3'h1 |-> sel == 2'h1)
    else $error("ID code not decoded");
  AST_SAMPLE_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
    st.ir == 3'h4 |-> sel == 2'h0 && !mem_out_float)
    else $error("sample code decoded wrong");

  AST_IR_UPDATE_ONLY: assert property (@(posedge core_clk) disable iff (!resetn)
    ($changed(st.ir) && st.state != SBT_RESET) |-> st.state == SBT_UPD_IR)
    else $error("instruction changed outside update");
  AST_RESET_ID: assert property (@(posedge core_clk) disable iff (!resetn)
    (st.state == SBT_RESET && tck_rise) |=> st.ir == `SBT_OP_IDCODE)
    else $error("reset did not load ID instruction");
  AST_TDO_FLOAT: assert property (@(posedge core_clk) disable iff (!resetn)
    (tck_fall && st.state != SBT_SH_DR && st.state != SBT_SH_IR) |=> !link_out.tdo_oe)
    else $error("TDO driven outside shift");
  AST_FLOAT_OUT: assert property (@(posedge core_clk) disable iff (!resetn)
    mem_out_float == (st.ir == 3'h0 || st.ir == 3'h2))
    else $error("float decode wrong");
  AST_CAP_IR: assert property (@(posedge core_clk) disable iff (!resetn)
    (tck_rise && st.state == SBT_CAP_IR) |=> st.ir_shift[1:0] == 2'h1)
    else $error("capture-IR pattern wrong");
  AST_ID_CAP: assert property (@(posedge core_clk) disable iff (!resetn)
    (tck_rise && st.state == SBT_CAP_DR && st.ir == 3'h1) |=> st.idr == ID_CODE)
    else $error("ID code not captured");
  AST_BSR_CAP: assert property (@(posedge core_clk) disable iff (!resetn)
    (tck_rise && st.state == SBT_CAP_DR && sel == 2'h0) |=> st.bsr == $past(st.pin_sync))
    else $error("boundary chain not captured");
  AST_UPD_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    (tck_rise && st.state == SBT_UPD_DR) |=> $stable(st.bsr))
    else $error("update changed boundary chain");
  AST_BYP_SHIFT: assert property (@(posedge core_clk) disable iff (!resetn)
    (tck_rise && st.state == SBT_SH_DR && sel == 2'h2) |=> st.bypass == $past(tdi_s))
    else $error("bypass bit not shifted");
  AST_TMS_RESET: assert property (@(posedge core_clk) disable iff (!resetn)
    s_tms_fifth |=> st.state == SBT_RESET)
    else $error("five TMS highs did not reset");

endmodule
`default_nettype wire

// ==== dv/sbt_ctrl_model.sv ====
// Behavioural scan controller that drives the serial test link
`default_nettype none
module sbt_ctrl_model
  import sbt_pkg::*;
(
  input wire logic core_clk,
  output sbt_link_in_s link_in,
  input wire sbt_link_out_s link_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_tdo = 1'b0;
  logic tdo_wire;
  // No pull on the released line, so show the inverse of its last level
  assign tdo_wire = link_out.tdo_oe ? link_out.tdo : ~last_tdo;
  always @(posedge core_clk) if (link_out.tdo_oe) last_tdo <= link_out.tdo;
  initial link_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
  ////////////////////////////////////////////////////////////////////////////
  // Half period of 8 core clocks: 80 ns, well under the 20 MHz limit
  task automatic half();
    repeat (8) @(posedge core_clk);
    #1;
  endtask
  // One test clock; the clock stands low between calls
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    link_in.tms = tms;
    link_in.tdi = tdi;
    half();
    tdo = tdo_wire;
    link_in.tck = 1'b1;
    half();
    link_in.tck = 1'b0;
  endtask
  // Idle, select, capture, shift n bits, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
  // Five high mode-select edges, then to idle
  task automatic tap_reset();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule
`default_nettype wire

// ==== dv/sbt_tap_tb_top.sv ====
// Self-checking bench of the boundary-scan test port
`default_nettype none
`define SBT_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module sbt_tap_tb_top
  import sbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BW = 12;
  localparam logic [31:0] ID = 32'h1234_5671; // Arbitrary value
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [BW-1:0] pin_values = '0;
  sbt_link_in_s link_in;
  sbt_link_out_s link_out;
  logic mem_out_float;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h9b77;
  always #5 core_clk = ~core_clk;
  sbt_tap #(.BSR_W(BW), .ID_CODE(ID)) dut (.core_clk(core_clk), .resetn(resetn), .link_in(link_in),
    .link_out(link_out), .pin_values(pin_values), .mem_out_float(mem_out_float));
  sbt_ctrl_model ctl (.core_clk(core_clk), .link_in(link_in), .link_out(link_out));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Captured register leaves first, the fed bits follow it
  function automatic logic [63:0] stream(input logic [63:0] cap, input int len, input logic [63:0] din, input int n);
    return ((cap & ((64'h1 << len) - 1)) | (din << len)) & ((64'h1 << n) - 1);
  endfunction
  function automatic int dr_len(input logic [2:0] op);
    case (op)
      3'h0, 3'h2, 3'h4: return BW;
      3'h1: return 32;
      default: return 1;
    endcase
  endfunction
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #900_000;
    error_cnt++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] din;
    logic [63:0] dout;
    logic [63:0] cap;
    logic [2:0] op;
    int n;
    repeat (16) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    `SBT_CHK("tdo_oe", 1'b0, link_out.tdo_oe)
    `SBT_CHK("float", 1'b0, mem_out_float)
    // The controller leaves test-logic-reset for idle before its first scan
    ctl.tap_reset();
    for (int k = 0; k < 10; k++) begin
      op = 3'(7 - k);
      if (op == 3'h3 || op == 3'h5) op = 3'h6;
      if (k < 8) begin
        din = {rnd(), 29'(rnd()), op};
        ctl.scan(1'b1, 3, din, dout);
        `SBT_CHK("ir_capture", 2'h1, dout[1:0])
      end else begin
        // Back to identification by mode-select reset in the last two passes, the first after the floating code
        ctl.tap_reset();
        op = 3'h1;
      end
      `SBT_CHK("float", op == 3'h0 || op == 3'h2, mem_out_float)
      pin_values = BW'(rnd());
      din = {rnd(), rnd()};
      n = dr_len(op) + 8;
      cap = op == 3'h1 ? 64'(ID) : (n == 9 ? 64'h0 : 64'(pin_values));
      ctl.scan(1'b0, n, din, dout);
      `SBT_CHK("dr_stream", stream(cap, dr_len(op), din, n), dout)
      `SBT_CHK("tdo_oe", 1'b0, link_out.tdo_oe)
    end
    end_of_test();
  end
endmodule
`default_nettype wire
